// ==== src/ucd_pkg.sv ====
package ucd_pkg;

    localparam int unsigned CLK_PERIOD_NS        = 25;
    localparam int unsigned IGNITION_MIN_US      = 7500;
    localparam int unsigned IGNITION_MAX_US      = 22000;
    localparam int unsigned IGNITION_DEGLITCH_CYC =
        (IGNITION_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned IGNITION_CNT_W       = 20;
    localparam logic [1:0]  STRAP_SETTLE_CYC     = 2'h3;

    // Code without parity, and the byte it travels as
    localparam logic [6:0] WRITE_LOCK_CODE       = 7'h5E;
    localparam logic [7:0] WRITE_LOCK_CMD        = {WRITE_LOCK_CODE, 1'b1};
    localparam logic [7:0] WRITE_UNLOCK_CMD      = 8'hBB;
    localparam logic [7:0] READ_IDENTITY_CMD     = 8'h06;
    localparam logic [7:0] READ_REVISION_CMD     = 8'h0C;
    localparam logic [7:0] WRITE_CONFIG_ONE_CMD  = 8'hB7;
    localparam logic [7:0] READ_CONFIG_ONE_CMD   = 8'h47;
    localparam logic [7:0] READ_WAKE_STATUS_CMD  = 8'h11;
    localparam logic [7:0] CAN_STANDBY_CMD       = 8'h7D;
    localparam logic [7:0] WRITE_SAFETY_FUNC_CMD = 8'h35;
    localparam logic [7:0] WRITE_CFG_CRC_CMD     = 8'h63;
    localparam logic [7:0] WRITE_PWM_HIGH_CMD    = 8'hD8;
    localparam logic [7:0] WRITE_PWM_LOW_CMD     = 8'h7E;
    localparam logic [7:0] WRITE_TOKEN_FDBK_CMD  = 8'h77;
    localparam logic [7:0] WRITE_WIN1_CMD        = 8'hED;
    localparam logic [7:0] WRITE_WIN2_CMD        = 8'h09;
    localparam logic [7:0] WRITE_PWD_THR_CMD     = 8'h93;
    localparam logic [7:0] WRITE_DIAG_CTRL_CMD   = 8'hCC;
    localparam logic [7:0] WRITE_DIAG_MUX_CMD    = 8'hC9;

    localparam logic [7:0] LOCK_KEY              = 8'hAA;
    localparam logic [7:0] UNLOCK_KEY            = 8'h55;
    localparam logic [7:0] STANDBY_KEY           = 8'h00;

    // Arbitrary values
    localparam logic [7:0] DEVICE_IDENTIFIER_VAL = 8'h5A;
    localparam logic [7:0] DEVICE_REVISION_VAL   = 8'h21;

    localparam int unsigned CFG_SUPPLY_SEL_BIT   = 7;
    localparam int unsigned CFG_UNMASK_BIT       = 6;
    localparam int unsigned WAKE_CAN_BIT         = 1;
    localparam int unsigned WAKE_IGNITION_BIT    = 0;
    localparam logic        CFG_UNMASK_RST       = 1'b0;
    localparam logic        WAKE_BIT_RST         = 1'b0;
    localparam logic        STRAP_RST            = 1'b0;

    typedef struct packed {
        logic [6:0] code;
        logic       parity;
        logic [7:0] data;
    } ucd_frame_type;

    typedef struct packed {
        logic [7:0] rd_data;
        logic       wr_access;
        logic       cmd_err;
    } ucd_rsp_type;

    typedef struct packed {
        logic [7:0] cmd;
        logic [7:0] data;
    } ucd_ext_wr_type;

    typedef struct packed {
        logic defined;
        logic is_write;
        logic lock_prot;
        logic diag_only;
        logic external;
    } ucd_cls_type;

endpackage : ucd_pkg

// ==== src/ucd_deglitch.sv ====
`timescale 1ns/100ps
module ucd_deglitch #(
    parameter int unsigned COUNT = ucd_pkg::IGNITION_DEGLITCH_CYC
) (
    input  wire logic i_sys_clk,
    input  wire logic i_reset_n,
    input  wire logic i_level,
    output logic      o_level
);
    import ucd_pkg::*;

    localparam logic [IGNITION_CNT_W-1:0] LAST =
        IGNITION_CNT_W'(COUNT - 1);

    logic [IGNITION_CNT_W-1:0] cnt_reg;
    logic                      level_reg;

    // Level flips only after COUNT stable cycles
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            cnt_reg   <= '0;
            level_reg <= WAKE_BIT_RST;
        end else if (i_level == level_reg) begin
            cnt_reg <= '0;
        end else if (cnt_reg == LAST) begin
            cnt_reg   <= '0;
            level_reg <= i_level;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    assign o_level = level_reg;

    property p_filter_hold;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        $changed(level_reg) |-> $past(cnt_reg) == LAST;
    endproperty
    a_filter_hold : assert property (p_filter_hold)
        else $error("filtered level changed before the deglitch time");

endmodule : ucd_deglitch

// ==== src/ucd_cmd_decode.sv ====
`timescale 1ns/100ps
module ucd_cmd_decode #(
    parameter int unsigned IGNITION_CYCLES = ucd_pkg::IGNITION_DEGLITCH_CYC
) (
    input  wire logic                    i_sys_clk,
    input  wire logic                    i_reset_n,
    input  wire logic                    i_link_clk,
    input  wire logic                    i_link_reset_n,
    input  wire logic                    i_link_frame_valid,
    input  wire ucd_pkg::ucd_frame_type  i_link_frame,
    input  wire logic                    i_diag_state,
    input  wire logic                    i_selftest_done,
    input  wire logic                    i_global_standby,
    input  wire logic                    i_can_wake_pin,
    input  wire logic                    i_ignition_level,
    input  wire logic                    i_io_voltage_select_pin,
    input  wire logic                    i_core_supply_ov,
    input  wire logic                    i_core_supply_uv,
    output logic                         o_rsp_valid,
    output ucd_pkg::ucd_rsp_type         o_rsp,
    output logic                         o_write_locked,
    output logic                         o_can_standby,
    output logic                         o_ext_wr_valid,
    output ucd_pkg::ucd_ext_wr_type      o_ext_wr,
    output logic                         o_enable_drive_off,
    output logic                         o_mcu_reset_req
);
    import ucd_pkg::*;

    function automatic ucd_cls_type classify(input logic [7:0] cmd);
        ucd_cls_type c;
        c = '0;
        unique case (cmd)
            WRITE_LOCK_CMD, WRITE_UNLOCK_CMD:
                c = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
            READ_IDENTITY_CMD, READ_REVISION_CMD,
            READ_CONFIG_ONE_CMD, READ_WAKE_STATUS_CMD:
                c = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
            WRITE_CONFIG_ONE_CMD:
                c = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
            CAN_STANDBY_CMD:
                c = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
            WRITE_SAFETY_FUNC_CMD, WRITE_CFG_CRC_CMD,
            WRITE_PWM_HIGH_CMD, WRITE_PWM_LOW_CMD,
            WRITE_TOKEN_FDBK_CMD, WRITE_WIN1_CMD, WRITE_WIN2_CMD:
                c = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
            WRITE_PWD_THR_CMD, WRITE_DIAG_CTRL_CMD, WRITE_DIAG_MUX_CMD:
                c = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
            default:
                c = '0;
        endcase
        return c;
    endfunction : classify

    // Link side: hold the frame, flag it with a toggle
    ucd_frame_type link_frame_reg;
    logic          link_tgl_reg;

    always_ff @(posedge i_link_clk) begin
        if (!i_link_reset_n) begin
            link_frame_reg <= '0;
            link_tgl_reg   <= 1'b0;
        end else if (i_link_frame_valid) begin
            link_frame_reg <= i_link_frame;
            link_tgl_reg   <= ~link_tgl_reg;
        end
    end

    // Crossings into the system clock
    logic [2:0] tgl_sync_reg;
    logic [2:0] can_sync_reg;
    logic [1:0] ignition_sync_reg;
    logic [1:0] sel_sync_reg;

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            tgl_sync_reg <= '0;
            can_sync_reg <= '0;
            ignition_sync_reg <= '0;
            sel_sync_reg <= '0;
        end else begin
            tgl_sync_reg <= {tgl_sync_reg[1:0], link_tgl_reg};
            can_sync_reg <= {can_sync_reg[1:0], i_can_wake_pin};
            ignition_sync_reg <= {ignition_sync_reg[0], i_ignition_level};
            sel_sync_reg <= {sel_sync_reg[0], i_io_voltage_select_pin};
        end
    end

    logic          new_frame;
    logic          can_rise;
    ucd_frame_type frame;
    logic [7:0]    cmd_byte;
    logic          parity_ok;
    ucd_cls_type   cls;
    logic          frame_ok;
    logic          wr_allowed;
    logic          standby_cmd;
    logic          ignition_filt;
    logic          lock_reg;

    // Frame word is stable: next frame is far beyond the sync delay
    assign new_frame = tgl_sync_reg[2] ^ tgl_sync_reg[1];
    assign can_rise  = can_sync_reg[1] & ~can_sync_reg[2];
    assign frame     = link_frame_reg;
    assign cmd_byte  = {frame.code, frame.parity};
    assign parity_ok = ~^cmd_byte;
    assign cls       = classify(cmd_byte);
    assign frame_ok  = new_frame & parity_ok & cls.defined;
    assign wr_allowed = frame_ok & cls.is_write
                      & ~(cls.lock_prot & lock_reg)
                      & ~(cls.diag_only & ~i_diag_state);
    assign standby_cmd = wr_allowed & (cmd_byte == CAN_STANDBY_CMD)
                       & (frame.data == STANDBY_KEY);

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            lock_reg <= 1'b0;
        end else if (frame_ok && cmd_byte == WRITE_LOCK_CMD
                     && frame.data == LOCK_KEY) begin
            lock_reg <= 1'b1;
        end else if (frame_ok && cmd_byte == WRITE_UNLOCK_CMD
                     && frame.data == UNLOCK_KEY) begin
            lock_reg <= 1'b0;
        end
    end

    logic cfg_unmask_reg;

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            cfg_unmask_reg <= CFG_UNMASK_RST;
        end else if (wr_allowed && cmd_byte == WRITE_CONFIG_ONE_CMD) begin
            cfg_unmask_reg <= frame.data[CFG_UNMASK_BIT];
        end
    end

    // Supply select strap caught once after reset release
    logic [1:0] strap_cnt_reg;
    logic       strap_done_reg;
    logic       strap_reg;

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            strap_cnt_reg  <= '0;
            strap_done_reg <= 1'b0;
            strap_reg      <= STRAP_RST;
        end else if (!strap_done_reg) begin
            if (strap_cnt_reg == STRAP_SETTLE_CYC) begin
                strap_done_reg <= 1'b1;
                strap_reg      <= sel_sync_reg[1];
            end else begin
                strap_cnt_reg <= strap_cnt_reg + 1'b1;
            end
        end
    end

    ucd_deglitch #(
        .COUNT     (IGNITION_CYCLES)
    ) u_ignition_filter (
        .i_sys_clk (i_sys_clk),
        .i_reset_n (i_reset_n),
        .i_level   (ignition_sync_reg[1]),
        .o_level   (ignition_filt)
    );

    logic wake_can_reg;
    logic wake_ignition_reg;

    // CAN wake latch: a new CAN wake-up wins over the self-test and standby clears, not over reset
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            wake_can_reg <= WAKE_BIT_RST;
        end else if (can_rise) begin
            wake_can_reg <= 1'b1;
        end else if (i_selftest_done) begin
            wake_can_reg <= WAKE_BIT_RST;
        end else if (standby_cmd || i_global_standby) begin
            wake_can_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n || i_selftest_done) begin
            wake_ignition_reg <= WAKE_BIT_RST;
        end else begin
            wake_ignition_reg <= ignition_filt & ~i_global_standby;
        end
    end

    logic [7:0] rd_value;

    always_comb begin
        rd_value = '0;
        unique case (cmd_byte)
            READ_IDENTITY_CMD:    rd_value = DEVICE_IDENTIFIER_VAL;
            READ_REVISION_CMD:    rd_value = DEVICE_REVISION_VAL;
            READ_WAKE_STATUS_CMD: begin
                rd_value[WAKE_CAN_BIT]      = wake_can_reg;
                rd_value[WAKE_IGNITION_BIT] = wake_ignition_reg;
            end
            READ_CONFIG_ONE_CMD:  begin
                rd_value[CFG_SUPPLY_SEL_BIT] = strap_reg;
                rd_value[CFG_UNMASK_BIT]     = cfg_unmask_reg;
            end
            default:              rd_value = '0;
        endcase
    end

    logic           rsp_valid_reg;
    ucd_rsp_type    rsp_reg;

    // Every frame answers, blocked writes included
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            rsp_valid_reg <= 1'b0;
            rsp_reg       <= '0;
        end else begin
            rsp_valid_reg <= new_frame;
            if (new_frame) begin
                rsp_reg.cmd_err   <= ~(parity_ok & cls.defined);
                rsp_reg.wr_access <= frame_ok & cls.is_write;
                rsp_reg.rd_data   <= (frame_ok && !cls.is_write)
                                     ? rd_value : 8'h00;
            end
        end
    end

    logic           standby_reg;
    logic           ext_valid_reg;
    ucd_ext_wr_type ext_wr_reg;

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            standby_reg   <= 1'b0;
            ext_valid_reg <= 1'b0;
            ext_wr_reg    <= '0;
        end else begin
            standby_reg   <= standby_cmd;
            ext_valid_reg <= wr_allowed & cls.external;
            if (wr_allowed && cls.external) begin
                ext_wr_reg <= '{cmd_byte, frame.data};
            end
        end
    end

    logic drive_off_reg;
    logic reset_req_reg;

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            drive_off_reg <= 1'b0;
            reset_req_reg <= 1'b0;
        end else begin
            drive_off_reg <= i_core_supply_ov & cfg_unmask_reg;
            reset_req_reg <= i_core_supply_uv & cfg_unmask_reg;
        end
    end

    assign o_rsp_valid        = rsp_valid_reg;
    assign o_rsp              = rsp_reg;
    assign o_write_locked     = lock_reg;
    assign o_can_standby      = standby_reg;
    assign o_ext_wr_valid     = ext_valid_reg;
    assign o_ext_wr           = ext_wr_reg;
    assign o_enable_drive_off = drive_off_reg;
    assign o_mcu_reset_req    = reset_req_reg;

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);

    property p_parity;
        new_frame && (^cmd_byte) |=> o_rsp_valid && o_rsp.cmd_err;
    endproperty
    a_parity : assert property (p_parity)
        else $error("bad parity not flagged");

    property p_lock;
        new_frame && cmd_byte == 8'hBD && frame.data == 8'hAA
        |=> o_write_locked;
    endproperty
    a_lock : assert property (p_lock)
        else $error("lock command did not engage lock");

    property p_unlock;
        new_frame && cmd_byte == 8'hBB && frame.data == 8'h55
        |=> !o_write_locked;
    endproperty
    a_unlock : assert property (p_unlock)
        else $error("unlock command did not release lock");

    property p_lock_keep;
        new_frame && (cmd_byte == 8'hBD || cmd_byte == 8'hBB)
        && frame.data != 8'hAA && frame.data != 8'h55
        |=> $stable(o_write_locked);
    endproperty
    a_lock_keep : assert property (p_lock_keep)
        else $error("lock changed on wrong data byte");

    property p_cfg_blocked;
        new_frame && cmd_byte == 8'hB7 && (!i_diag_state || lock_reg)
        |=> $stable(cfg_unmask_reg) ##2 $stable(o_mcu_reset_req);
    endproperty
    a_cfg_blocked : assert property (p_cfg_blocked)
        else $error("config write taken outside diag state or locked");

    property p_ext_diag;
        new_frame && cls.diag_only && !i_diag_state |=> !o_ext_wr_valid;
    endproperty
    a_ext_diag : assert property (p_ext_diag)
        else $error("diagnostic-only write passed outside diag state");

    property p_identity;
        new_frame && cmd_byte == 8'h06 |=> o_rsp.rd_data == 8'h5A;
    endproperty
    a_identity : assert property (p_identity)
        else $error("identity read wrong");

    property p_revision;
        new_frame && cmd_byte == 8'h0C |=> o_rsp.rd_data == 8'h21;
    endproperty
    a_revision : assert property (p_revision)
        else $error("revision read wrong");

    property p_standby_key;
        new_frame && cmd_byte == 8'h7D && frame.data != 8'h00
        |=> !o_can_standby;
    endproperty
    a_standby_key : assert property (p_standby_key)
        else $error("standby accepted with nonzero data");

    property p_can_clear;
        i_global_standby && !can_rise |=> !wake_can_reg;
    endproperty
    a_can_clear : assert property (p_can_clear)
        else $error("CAN wake latch not cleared on standby");

    property p_masked;
        !cfg_unmask_reg |=> !o_enable_drive_off && !o_mcu_reset_req;
    endproperty
    a_masked : assert property (p_masked)
        else $error("masked core monitor reached an output");

    c_lock      : cover property (new_frame && cmd_byte == WRITE_LOCK_CMD);
    c_cfg_write : cover property (wr_allowed
                                  && cmd_byte == WRITE_CONFIG_ONE_CMD);
    c_standby   : cover property (o_can_standby);
    c_ext_write : cover property (o_ext_wr_valid);

endmodule : ucd_cmd_decode

// ==== test/ucd_link_master.sv ====
`timescale 1ns/100ps
module ucd_link_master (
    output logic                   o_link_clk,
    output logic                   o_link_reset_n,
    output logic                   o_frame_valid,
    output ucd_pkg::ucd_frame_type o_frame
);
    import ucd_pkg::*;

    initial begin
        o_link_clk     = 1'b0;
        o_link_reset_n = 1'b0;
        o_frame_valid  = 1'b0;
        o_frame        = '0;
    end

    // Link clock runs only inside frames and resets
    task automatic tick;
        #7.5 o_link_clk = 1'b1;
        #7.5 o_link_clk = 1'b0;
    endtask : tick

    task automatic reset_link;
        o_link_reset_n = 1'b0;
        repeat (3) tick();
        o_link_reset_n = 1'b1;
        tick();
    endtask : reset_link

    task automatic send(input logic [7:0] cmd, input logic [7:0] data);
        o_frame       = {cmd, data};
        o_frame_valid = 1'b1;
        tick();
        o_frame_valid = 1'b0;
        // Released word shows the inverse, never the old value
        o_frame       = ~o_frame;
        tick();
    endtask : send
endmodule : ucd_link_master

// ==== test/testbench.sv ====
`timescale 1ns/100ps
module testbench;
    import ucd_pkg::*;

    localparam int unsigned IGNITION_CYC = 8;

    logic           i_sys_clk, i_reset_n, i_diag_state, i_selftest_done;
    logic           i_global_standby, i_can_wake_pin, i_ignition_level;
    logic           i_io_voltage_select_pin, i_core_supply_ov;
    logic           i_core_supply_uv, link_clk, link_reset_n, frame_valid;
    ucd_frame_type  frame;
    logic           o_rsp_valid, o_write_locked, o_can_standby;
    logic           o_ext_wr_valid, o_enable_drive_off, o_mcu_reset_req;
    ucd_rsp_type    o_rsp;
    ucd_ext_wr_type o_ext_wr, ew;
    logic [7:0]     rd;
    logic           err, wra, ext, stb;
    int             errors = 0;
    int             compares = 0;

    ucd_link_master u_link (
        .o_link_clk     (link_clk),
        .o_link_reset_n (link_reset_n),
        .o_frame_valid  (frame_valid),
        .o_frame        (frame)
    );

    ucd_cmd_decode #(.IGNITION_CYCLES(IGNITION_CYC)) DUT (
        .i_sys_clk               (i_sys_clk),
        .i_reset_n               (i_reset_n),
        .i_link_clk              (link_clk),
        .i_link_reset_n          (link_reset_n),
        .i_link_frame_valid      (frame_valid),
        .i_link_frame            (frame),
        .i_diag_state            (i_diag_state),
        .i_selftest_done         (i_selftest_done),
        .i_global_standby        (i_global_standby),
        .i_can_wake_pin          (i_can_wake_pin),
        .i_ignition_level        (i_ignition_level),
        .i_io_voltage_select_pin (i_io_voltage_select_pin),
        .i_core_supply_ov        (i_core_supply_ov),
        .i_core_supply_uv        (i_core_supply_uv),
        .o_rsp_valid             (o_rsp_valid),
        .o_rsp                   (o_rsp),
        .o_write_locked          (o_write_locked),
        .o_can_standby           (o_can_standby),
        .o_ext_wr_valid          (o_ext_wr_valid),
        .o_ext_wr                (o_ext_wr),
        .o_enable_drive_off      (o_enable_drive_off),
        .o_mcu_reset_req         (o_mcu_reset_req)
    );

    initial begin
        i_sys_clk = 1'b0;
        forever #12.5 i_sys_clk = ~i_sys_clk;
    end

    task automatic print_verdict;
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : print_verdict

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t byte %h expected %h", $time, got, exp);
        end
    endtask : chk_byte

    task automatic chk_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
        end
    endtask : chk_bit

    // One frame, answer captured in its single valid cycle
    task automatic xfer(input logic [7:0] c, input logic [7:0] d);
        int n;
        n = 0;
        u_link.send(c, d);
        do begin
            @(negedge i_sys_clk);
            n++;
        end while (o_rsp_valid !== 1'b1 && n < 20);
        if (o_rsp_valid !== 1'b1) begin
            errors++;
            $display("[FAIL] %0t no answer", $time);
            print_verdict();
        end else begin
            rd  = o_rsp.rd_data;
            err = o_rsp.cmd_err;
            wra = o_rsp.wr_access;
            ext = o_ext_wr_valid;
            stb = o_can_standby;
            ew  = o_ext_wr;
        end
        repeat (8) @(negedge i_sys_clk);
    endtask : xfer

    task automatic t_ids;
        xfer(READ_IDENTITY_CMD, 8'h00);
        chk_byte(rd, DEVICE_IDENTIFIER_VAL);
        chk_bit(err, 1'b0);
        xfer(READ_REVISION_CMD, 8'h00);
        chk_byte(rd, DEVICE_REVISION_VAL);
        $display("test ids done");
    endtask : t_ids

    task automatic t_err;
        xfer(8'h07, 8'h00);
        chk_bit(err, 1'b1);
        chk_byte(rd, 8'h00);
        xfer(8'h0F, 8'h00);
        chk_bit(err, 1'b1);
        xfer(8'hBC, LOCK_KEY);
        chk_bit(o_write_locked, 1'b0);
        $display("test err done");
    endtask : t_err

    task automatic t_cfg;
        xfer(WRITE_CONFIG_ONE_CMD, 8'h40);
        chk_bit(wra, 1'b1);
        xfer(READ_CONFIG_ONE_CMD, 8'h00);
        chk_byte(rd, 8'h80);
        @(posedge i_sys_clk) i_core_supply_ov <= 1'b1;
        repeat (3) @(negedge i_sys_clk);
        chk_bit(o_enable_drive_off, 1'b0);
        @(posedge i_sys_clk) i_diag_state <= 1'b1;
        xfer(WRITE_CONFIG_ONE_CMD, 8'h7F);
        xfer(READ_CONFIG_ONE_CMD, 8'h00);
        chk_byte(rd, 8'hC0);
        @(posedge i_sys_clk) i_core_supply_uv <= 1'b1;
        repeat (3) @(negedge i_sys_clk);
        chk_bit(o_enable_drive_off, 1'b1);
        chk_bit(o_mcu_reset_req, 1'b1);
        xfer(WRITE_CONFIG_ONE_CMD, 8'h00);
        chk_bit(o_mcu_reset_req, 1'b0);
        @(posedge i_sys_clk) {i_core_supply_ov, i_core_supply_uv} <= 2'h0;
        $display("test cfg done");
    endtask : t_cfg

    task automatic t_lock;
        xfer(WRITE_LOCK_CMD, LOCK_KEY);
        chk_bit(o_write_locked, 1'b1);
        xfer(WRITE_CONFIG_ONE_CMD, 8'h40);
        chk_bit(wra, 1'b1);
        xfer(READ_CONFIG_ONE_CMD, 8'h00);
        chk_byte(rd, 8'h80);
        xfer(WRITE_UNLOCK_CMD, 8'h00);
        chk_bit(o_write_locked, 1'b1);
        xfer(WRITE_UNLOCK_CMD, UNLOCK_KEY);
        chk_bit(o_write_locked, 1'b0);
        xfer(WRITE_LOCK_CMD, 8'h00);
        chk_bit(o_write_locked, 1'b0);
        $display("test lock done");
    endtask : t_lock

    task automatic t_ext;
        logic [7:0] c [3] = '{WRITE_SAFETY_FUNC_CMD, WRITE_CFG_CRC_CMD,
                              WRITE_PWM_HIGH_CMD};
        @(posedge i_sys_clk) i_diag_state <= 1'b0;
        xfer(WRITE_SAFETY_FUNC_CMD, 8'h12);
        chk_bit(ext, 1'b0);
        xfer(WRITE_PWD_THR_CMD, 8'h21);
        chk_bit(ext, 1'b1);
        chk_byte(ew.cmd, WRITE_PWD_THR_CMD);
        @(posedge i_sys_clk) i_diag_state <= 1'b1;
        foreach (c[k]) begin
            xfer(c[k], 8'h30 + 8'(k));
            chk_bit(ext, 1'b1);
            chk_byte(ew.cmd, c[k]);
            chk_byte(ew.data, 8'h30 + 8'(k));
        end
        $display("test ext done");
    endtask : t_ext

    task automatic t_wake;
        @(posedge i_sys_clk) i_can_wake_pin <= 1'b1;
        repeat (4) @(negedge i_sys_clk);
        xfer(READ_WAKE_STATUS_CMD, 8'h00);
        chk_byte(rd, 8'h02);
        @(posedge i_sys_clk) i_can_wake_pin <= 1'b0;
        @(posedge i_sys_clk) i_selftest_done <= 1'b1;
        @(posedge i_sys_clk) i_selftest_done <= 1'b0;
        xfer(READ_WAKE_STATUS_CMD, 8'h00);
        chk_byte(rd, 8'h00);
        @(posedge i_sys_clk) i_can_wake_pin <= 1'b1;
        repeat (4) @(negedge i_sys_clk);
        xfer(CAN_STANDBY_CMD, 8'h01);
        chk_bit(stb, 1'b0);
        xfer(CAN_STANDBY_CMD, STANDBY_KEY);
        chk_bit(stb, 1'b1);
        xfer(READ_WAKE_STATUS_CMD, 8'h00);
        chk_byte(rd, 8'h00);
        @(posedge i_sys_clk) i_ignition_level <= 1'b1;
        repeat (IGNITION_CYC + 12) @(negedge i_sys_clk);
        xfer(READ_WAKE_STATUS_CMD, 8'h00);
        chk_byte(rd, 8'h01);
        @(posedge i_sys_clk) i_global_standby <= 1'b1;
        xfer(READ_WAKE_STATUS_CMD, 8'h00);
        chk_byte(rd, 8'h00);
        @(posedge i_sys_clk) {i_global_standby, i_ignition_level} <= 2'h0;
        $display("test wake done");
    endtask : t_wake

    initial begin
        {i_diag_state, i_selftest_done, i_global_standby} = 3'h0;
        {i_can_wake_pin, i_ignition_level} = 2'h0;
        {i_core_supply_ov, i_core_supply_uv} = 2'h0;
        i_io_voltage_select_pin = 1'b1;
        i_reset_n = 1'b0;
        u_link.reset_link();
        repeat (16) @(posedge i_sys_clk);
        i_reset_n <= 1'b1;
        repeat (8) @(negedge i_sys_clk);
        t_ids();
        t_err();
        t_cfg();
        t_lock();
        t_ext();
        t_wake();
        print_verdict();
    end
endmodule : testbench
